// File: pkg/lpsr_pkg.sv
// Package: register map, field positions, reset values and bus states
package lpsr_pkg;
    // APB address width in bits
    localparam int unsigned ADDR_W = 12;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_FAULT  = 8'h52;
    localparam logic [7:0] IDX_LINE   = 8'h53;
    localparam logic [7:0] IDX_TXSEL  = 8'h54;
    localparam logic [7:0] IDX_RXSEL  = 8'h55;
    localparam logic [7:0] IDX_MASK   = 8'h58;
    localparam logic [7:0] IDX_DIRECT = 8'h59;
    // Fault flag positions
    localparam int unsigned OT_BIT = 7;
    localparam int unsigned HF_BIT = 5;
    localparam int unsigned UV_BIT = 3;
    // Line state positions
    localparam int unsigned RDY_BIT = 7;
    localparam int unsigned RX_BIT  = 1;
    localparam int unsigned TX_BIT  = 0;
    // Source and destination select positions
    localparam int unsigned SEL_PB_BIT  = 1;
    localparam int unsigned SEL_SCI_BIT = 0;
    // Direct transmitter control position
    localparam int unsigned DIRECT_BIT = 0;
    // Implemented fault bits
    localparam logic [7:0] FAULT_USED = 8'hA8;
    // Reset values
    localparam logic [7:0] FAULT_RST  = 8'h00;
    localparam logic [1:0] SEL_RST    = 2'h0;
    localparam logic [7:0] MASK_RST   = 8'h00;
    localparam logic       DIRECT_RST = 1'h0;
    // Bus slave states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ANS  = 2'b10
    } lpsr_bus_e;
endpackage

// File: core/lpsr_sync.sv
// Two-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
module lpsr_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second stage
    for (genvar g = 0; g < W; g++) begin : g_bit
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                meta_reg[g] <= 1'b0;
                sync_o[g]   <= 1'b0;
            end else begin
                meta_reg[g] <= async_i[g];
                sync_o[g]   <= meta_reg[g];
            end
        end
    end
endmodule

// File: core/lpsr_route.sv
// Transmit source selection and receive line distribution
`timescale 1ns/1ps
module lpsr_route (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic sel_sci_i,
    input  wire logic sel_pb_i,
    input  wire logic direct_i,
    input  wire logic sci_tx_i,
    input  wire logic pb_tx_i,
    input  wire logic rx_dom_i,
    input  wire logic dst_sci_i,
    input  wire logic dst_pb_i,
    output logic      lin_tx_o,
    output logic      pb_rx_o,
    output logic      sci_rx_o
);
    logic src;

    // Serial interface wins when both sources are chosen
    always_comb begin
        if (sel_sci_i) begin
            src = sci_tx_i;
        end else if (sel_pb_i) begin
            src = pb_tx_i;
        end else begin
            src = 1'b0;
        end
    end

    // Registered so every line leaves on a flop
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lin_tx_o <= 1'b0;
            pb_rx_o  <= 1'b0;
            sci_rx_o <= 1'b0;
        end else begin
            lin_tx_o <= src | direct_i;
            pb_rx_o  <= dst_pb_i & rx_dom_i;
            sci_rx_o <= dst_sci_i & rx_dom_i;
        end
    end
endmodule

// File: core/lpsr_top.sv
// LIN physical layer status flags, line state and routing registers
`timescale 1ns/1ps

// What this block does
// - Overtemperature sets sticky bit 7, W1C
// - HF disturbance sets sticky bit 5, W1C
// - Undervoltage sets sticky bit 3, W1C
// - Undervoltage threshold shared with low-voltage shutdown
// - Flags reset zero; unused fault bits read zero
// - Line state bit 7 shows transmitter ready
// - Line state bit 1 shows receive level
// - Line state bit 0 shows transmit level
// - Source bit 1 connects port B to transmitter
// - Source bit 0 connects serial interface transmitter
// - Both source bits reset to zero
// - Serial interface wins when both selected
// - Selected source ORed with direct control bit
// - Destination bit 1 routes receiver to port B
// - Destination bit 0 routes receiver to serial
// - Direct control bit forces transmitter dominant
module lpsr_top
    import lpsr_pkg::*;
(
    input  wire logic              CORE_CLK_I,
    input  wire logic              SYS_RST_I,
    input  wire logic              PSEL_I,
    input  wire logic              PENABLE_I,
    input  wire logic              PWRITE_I,
    input  wire logic [ADDR_W-1:0] PADDR_I,
    input  wire logic [31:0]       PWDATA_I,
    output logic      [31:0]       PRDATA_O,
    output logic                   PREADY_O,
    output logic                   PSLVERR_O,
    input  wire logic              OVERTEMP_DET_I,
    input  wire logic              HF_DISTURB_DET_I,
    input  wire logic              UNDERVOLT_DET_I,
    input  wire logic              TX_READY_I,
    input  wire logic              LIN_RX_DOM_I,
    input  wire logic              SERIAL_IF_TX_I,
    input  wire logic              PORT_B_TX_I,
    output logic                   LIN_TX_DOM_O,
    output logic                   PORT_B_RX_O,
    output logic                   SERIAL_IF_RX_O,
    output logic                   UV_SHUTDOWN_O,
    output logic                   IRQ_O
);

    ////////////////////////////////////////////////////////////////////
    // Declarations
    lpsr_bus_e   state_reg;
    logic [7:0]  fault_reg;
    logic [7:0]  fault_next;
    logic [7:0]  mask_reg;
    logic [1:0]  txsel_reg;
    logic [1:0]  rxsel_reg;
    logic        direct_reg;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;
    logic        irq_reg;
    logic        uvsd_reg;
    logic [4:0]  sync_s;
    logic        ot_s;
    logic        hf_s;
    logic        uv_s;
    logic        rdy_s;
    logic        rx_s;
    logic        lin_tx;
    logic        acc;
    logic        take;
    logic        wr;
    logic [7:0]  idx;
    logic        aligned;
    logic [7:0]  wr8;
    logic [7:0]  set_vec;
    logic [7:0]  clr_vec;
    logic [7:0]  line_rd;
    logic [7:0]  rd8;
    logic        hit;

    ////////////////////////////////////////////////////////////////////
    // Analog inputs cross into the clock domain
    lpsr_sync #(
        .W (5)
    ) u_sync (
        .clk_i   (CORE_CLK_I),
        .rst_i   (SYS_RST_I),
        .async_i ({OVERTEMP_DET_I, HF_DISTURB_DET_I, UNDERVOLT_DET_I,
                   TX_READY_I, LIN_RX_DOM_I}),
        .sync_o  (sync_s)
    );

    assign ot_s  = sync_s[4];
    assign hf_s  = sync_s[3];
    assign uv_s  = sync_s[2];
    assign rdy_s = sync_s[1];
    assign rx_s  = sync_s[0];

    ////////////////////////////////////////////////////////////////////
    // Line routing; serial and port B signals share our clock
    lpsr_route u_route (
        .clk_i     (CORE_CLK_I),
        .rst_i     (SYS_RST_I),
        .sel_sci_i (txsel_reg[SEL_SCI_BIT]),
        .sel_pb_i  (txsel_reg[SEL_PB_BIT]),
        .direct_i  (direct_reg),
        .sci_tx_i  (SERIAL_IF_TX_I),
        .pb_tx_i   (PORT_B_TX_I),
        .rx_dom_i  (rx_s),
        .dst_sci_i (rxsel_reg[SEL_SCI_BIT]),
        .dst_pb_i  (rxsel_reg[SEL_PB_BIT]),
        .lin_tx_o  (lin_tx),
        .pb_rx_o   (PORT_B_RX_O),
        .sci_rx_o  (SERIAL_IF_RX_O)
    );

    assign LIN_TX_DOM_O = lin_tx;

    ////////////////////////////////////////////////////////////////////
    // APB decode
    assign acc     = PSEL_I & PENABLE_I;
    assign take    = acc & (state_reg == ST_ANS);
    assign wr      = take & PWRITE_I & ~pslverr_reg;
    assign idx     = PADDR_I[9:2];
    assign aligned = (PADDR_I[1:0] == 2'h0) & (PADDR_I[11:10] == 2'h0);
    assign wr8     = PWDATA_I[7:0];

    // Live line state, rebuilt every cycle
    always_comb begin
        line_rd          = 8'h00;
        line_rd[RDY_BIT] = rdy_s;
        line_rd[RX_BIT]  = rx_s;
        line_rd[TX_BIT]  = lin_tx;
    end

    // Read mux; unknown addresses answer with an error
    always_comb begin
        rd8 = 8'h00;
        hit = aligned;
        if (idx == IDX_FAULT) begin
            rd8 = fault_reg & FAULT_USED;
        end else if (idx == IDX_LINE) begin
            rd8 = line_rd;
        end else if (idx == IDX_TXSEL) begin
            rd8 = {6'h00, txsel_reg};
        end else if (idx == IDX_RXSEL) begin
            rd8 = {6'h00, rxsel_reg};
        end else if (idx == IDX_MASK) begin
            rd8 = mask_reg & FAULT_USED;
        end else if (idx == IDX_DIRECT) begin
            rd8 = {7'h00, direct_reg};
        end else begin
            hit = 1'b0;
        end
        if (!aligned) begin
            rd8 = 8'h00;
        end
    end

    // One wait state: answer one cycle into the access phase
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (acc) begin
                        state_reg <= ST_ANS;
                    end
                end
                ST_ANS: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Read data and error are captured as the answer is raised
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (acc && state_reg == ST_IDLE) begin
            prdata_reg  <= PWRITE_I ? 32'h0000_0000 : {24'h000000, rd8};
            pslverr_reg <= ~hit;
        end else if (state_reg == ST_ANS) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
    end

    assign PRDATA_O  = prdata_reg;
    assign PREADY_O  = state_reg[1];  // One-hot answer bit, straight from the state flop
    assign PSLVERR_O = pslverr_reg;

    ////////////////////////////////////////////////////////////////////
    // Fault flags: detection wins over a clear in the same cycle
    always_comb begin
        set_vec         = 8'h00;
        set_vec[OT_BIT] = ot_s;
        set_vec[HF_BIT] = hf_s;
        set_vec[UV_BIT] = uv_s;
        clr_vec = (wr && idx == IDX_FAULT) ? wr8 : 8'h00;
        // Zero bits in the write leave the flag alone
        fault_next = ((fault_reg & ~clr_vec) | set_vec) & FAULT_USED;
    end

    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            fault_reg <= FAULT_RST;
        end else begin
            fault_reg <= fault_next;
        end
    end

    // Routing selects, direct control and interrupt mask; line state has no write path
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            txsel_reg  <= SEL_RST;
            rxsel_reg  <= SEL_RST;
            direct_reg <= DIRECT_RST;
            mask_reg   <= MASK_RST;
        end else if (wr) begin
            if (idx == IDX_TXSEL) begin
                txsel_reg <= wr8[1:0];
            end else if (idx == IDX_RXSEL) begin
                rxsel_reg <= wr8[1:0];
            end else if (idx == IDX_DIRECT) begin
                direct_reg <= wr8[DIRECT_BIT];
            end else if (idx == IDX_MASK) begin
                mask_reg <= wr8 & FAULT_USED;
            end
        end
    end

    // Interrupt and the shutdown comparator level
    // The undervoltage comparator feeds both the flag and shutdown, so shutdown is high in the cycle the flag sets
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            irq_reg  <= 1'b0;
            uvsd_reg <= 1'b0;
        end else begin
            irq_reg  <= |(fault_reg & mask_reg);
            uvsd_reg <= uv_s;
        end
    end

    assign IRQ_O         = irq_reg;
    assign UV_SHUTDOWN_O = uvsd_reg;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    // Clear write to the fault register with the overtemperature bit set
    sequence s_clr_ot;
        wr && idx == IDX_FAULT && wr8[OT_BIT];
    endsequence

    sequence s_no_det_ot;
        !ot_s;
    endsequence

    a_ot_sets: assert property (
        ot_s |=> fault_reg[OT_BIT]
    ) else $error("overtemp flag not set");

    a_ot_clears: assert property (
        s_clr_ot and s_no_det_ot |=> !fault_reg[OT_BIT]
    ) else $error("overtemp flag not cleared");

    a_hf_sticky: assert property (
        fault_reg[HF_BIT] && !(wr && idx == IDX_FAULT && wr8[HF_BIT])
            |=> fault_reg[HF_BIT]
    ) else $error("hf flag lost");

    a_uv_set_wins: assert property (
        uv_s && wr && idx == IDX_FAULT && wr8[UV_BIT] |=> fault_reg[UV_BIT]
    ) else $error("uv clear beat set");

    a_uv_shared: assert property (
        fault_reg[UV_BIT] && !$past(fault_reg[UV_BIT]) |-> UV_SHUTDOWN_O
    ) else $error("shutdown level disagrees with uv flag");

    a_unused_zero: assert property (
        (fault_reg & ~FAULT_USED) == 8'h00
    ) else $error("unused fault bit set");

    a_line_read: assert property (
        acc && state_reg == ST_IDLE && !PWRITE_I && aligned && idx == IDX_LINE
            |=> PREADY_O && PRDATA_O[RDY_BIT] == $past(rdy_s)
                && PRDATA_O[TX_BIT] == $past(lin_tx)
    ) else $error("line state read wrong");

    a_tx_select: assert property (
        txsel_reg[SEL_SCI_BIT] |=> LIN_TX_DOM_O == ($past(SERIAL_IF_TX_I) | $past(direct_reg))
    ) else $error("serial source not taken");

    a_rx_read: assert property (
        acc && state_reg == ST_IDLE && !PWRITE_I && aligned && idx == IDX_LINE
            |=> PRDATA_O[RX_BIT] == $past(rx_s)
    ) else $error("receive level read wrong");

    a_tx_none: assert property (
        txsel_reg == 2'h0 |=> LIN_TX_DOM_O == $past(direct_reg)
    ) else $error("transmitter driven with no source");

    // A write to the live line state must not disturb the routing registers
    a_line_ignored: assert property (
        wr && idx == IDX_LINE |=> $stable(txsel_reg) && $stable(rxsel_reg) && $stable(direct_reg)
    ) else $error("line state write changed a register");

    a_irq_clear: assert property (
        !(|(fault_reg & mask_reg)) |=> !IRQ_O
    ) else $error("interrupt stuck high");

    a_tx_portb: assert property (
        txsel_reg == 2'h2 |=> LIN_TX_DOM_O == ($past(PORT_B_TX_I) | $past(direct_reg))
    ) else $error("port B source not taken");

    a_direct_dom: assert property (
        direct_reg |=> LIN_TX_DOM_O
    ) else $error("direct control did not force dominant");

    a_rx_route: assert property (
        ##1 PORT_B_RX_O == ($past(rxsel_reg[SEL_PB_BIT]) & $past(rx_s))
            && SERIAL_IF_RX_O == ($past(rxsel_reg[SEL_SCI_BIT]) & $past(rx_s))
    ) else $error("receive routing wrong");

    a_irq_level: assert property (
        |(fault_reg & mask_reg) |=> IRQ_O
    ) else $error("interrupt missing");

    a_bus_answer: assert property (
        acc && state_reg == ST_IDLE |=> PREADY_O ##1 !PREADY_O
    ) else $error("bus answer timing");

endmodule

// File: verification/lpsr_far_model.sv
// Far-side model: serial interface and port B transmit levels, receive pickup
`timescale 1ns/1ps
module lpsr_far_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       sci_want_i,
    input  wire logic       pb_want_i,
    input  wire logic [1:0] lag_i,
    input  wire logic       pb_rx_i,
    output logic            sci_tx_o,
    output logic            pb_tx_o,
    output logic            capture_o
);
    logic [1:0] wait_reg;
    ////////////////////////////////////////////////////////////////////////////////
    // Levels move just after an edge, after up to three idle cycles, like a slow peer
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_reg <= 2'h0;
            sci_tx_o <= 1'b0;
            pb_tx_o  <= 1'b0;
        end else if ({sci_want_i, pb_want_i} == {sci_tx_o, pb_tx_o}) begin
            wait_reg <= lag_i;
        end else if (wait_reg != 2'h0) begin
            wait_reg <= wait_reg - 2'h1;
        end else begin
            sci_tx_o <= sci_want_i;
            pb_tx_o  <= pb_want_i;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // A port B pin set as pass-through hands the receive line to timer capture
    assign capture_o = pb_rx_i;
endmodule

// File: verification/testbench.sv
// Self-checking bench: APB register access, fault flags, interrupt and routing
`timescale 1ns/1ps
module testbench
    import lpsr_pkg::*;
;
    logic              clk, rst, psel, pen, pwr, ot, hf, uv, rdy, rx;
    logic              sci_tx, pb_tx, sci_want, pb_want, cap;
    logic [1:0]        lag;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, seed, cyc;
    logic              pready, pslverr, tx_dom, pb_rx, sci_rx, uv_sd, irq;
    logic [33:0]       exp_q[$];
    logic [33:0]       note;
    logic              exp_tx;
    int                fail_count, n_compared;
    ////////////////////////////////////////////////////////////////////////////////
    lpsr_top dut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .OVERTEMP_DET_I(ot),
        .HF_DISTURB_DET_I(hf), .UNDERVOLT_DET_I(uv), .TX_READY_I(rdy), .LIN_RX_DOM_I(rx),
        .SERIAL_IF_TX_I(sci_tx), .PORT_B_TX_I(pb_tx), .LIN_TX_DOM_O(tx_dom),
        .PORT_B_RX_O(pb_rx), .SERIAL_IF_RX_O(sci_rx), .UV_SHUTDOWN_O(uv_sd), .IRQ_O(irq));
    lpsr_far_model far (.clk_i(clk), .rst_i(rst), .sci_want_i(sci_want), .pb_want_i(pb_want),
        .lag_i(lag), .pb_rx_i(pb_rx), .sci_tx_o(sci_tx), .pb_tx_o(pb_tx), .capture_o(cap));
    ////////////////////////////////////////////////////////////////////////////////
    // Xorshift source, fixed start so every run repeats
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // Single exit point for the run
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // One APB transfer; the expected answer is queued for the monitor
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       input logic [7:0] ed, input logic ee);
        exp_q.push_back({~wr, ee, 24'h0, ed});
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= wr;
        paddr  <= ADDR_W'({idx, 2'b00});
        pwdata <= {rnd() & 32'hFFFFFF00} | {24'h0, wd};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        pen  <= 1'b0;
        // Idle edge so the next call never reassigns psel in this time step
        @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Monitor: each completed transfer takes the oldest queued note
    always @(posedge clk) begin
        if (psel && pen && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                note = exp_q.pop_front();
                check({31'h0, pslverr}, {31'h0, note[32]});
                if (note[33]) check(prdata, note[31:0]);
            end
        end
    end
    // Watchdog: a hang counts as a mismatch
    always @(posedge clk) begin
        cyc <= cyc + 32'h1;
        if (cyc == 32'h2710) begin
            fail_count++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst, psel, pen, pwr, ot, hf, uv, rdy, rx, sci_want, pb_want} = 11'h400;
        {paddr, pwdata, lag, cyc, fail_count, n_compared} = '0;
        seed = 32'h738B1C42;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        // Reset values, then unmapped places refuse
        apb(0, IDX_FAULT, 8'h00, 8'h00, 0);
        apb(0, IDX_TXSEL, 8'h00, 8'h00, 0);
        apb(0, IDX_RXSEL, 8'h00, 8'h00, 0);
        apb(0, IDX_LINE, 8'h00, 8'h00, 0);
        apb(0, 8'h56, 8'h00, 8'h00, 1);
        apb(1, 8'h57, 8'hFF, 8'h00, 1);
        // Each fault flag: set, survive zero write, raise and clear the interrupt
        for (int b = 3; b < 8; b += 2) begin
            {ot, hf, uv} <= {b == 7, b == 5, b == 3};
            repeat (4) @(posedge clk);
            check({31'h0, uv_sd}, {31'h0, b == 3});
            // Clear while the detector is still high: the set wins
            apb(1, IDX_FAULT, 8'h1 << b, 8'h00, 0);
            apb(0, IDX_FAULT, 8'h00, 8'h1 << b, 0);
            {ot, hf, uv} <= 3'h0;
            repeat (4) @(posedge clk);
            check({31'h0, irq}, 32'h0);
            apb(1, IDX_MASK, 8'h1 << b, 8'h00, 0);
            apb(0, IDX_MASK, 8'h00, 8'h1 << b, 0);
            repeat (2) @(posedge clk);
            check({31'h0, irq}, 32'h1);
            apb(0, IDX_FAULT, 8'h00, 8'h1 << b, 0);
            apb(1, IDX_FAULT, ~(8'h1 << b), 8'h00, 0);
            apb(0, IDX_FAULT, 8'h00, 8'h1 << b, 0);
            apb(1, IDX_FAULT, 8'h1 << b, 8'h00, 0);
            apb(0, IDX_FAULT, 8'h00, 8'h00, 0);
            repeat (2) @(posedge clk);
            check({31'h0, irq | uv_sd}, 32'h0);
            apb(1, IDX_MASK, 8'h00, 8'h00, 0);
        end
        // Transmit source, priority and direct control, every combination
        for (int s = 0; s < 8; s++) begin
            apb(1, IDX_TXSEL, {6'(rnd()), s[1:0]}, 8'h00, 0);
            apb(0, IDX_TXSEL, 8'h00, {6'h0, s[1:0]}, 0);
            apb(1, IDX_DIRECT, {7'h0, s[2]}, 8'h00, 0);
            apb(0, IDX_DIRECT, 8'h00, {7'h0, s[2]}, 0);
            for (int v = 0; v < 4; v++) begin
                {sci_want, pb_want} <= v[1:0];
                lag <= 2'(rnd());
                repeat (7) @(posedge clk);
                exp_tx = (s[0] ? v[1] : (s[1] & v[0])) | s[2];
                check({31'h0, tx_dom}, {31'h0, exp_tx});
                apb(0, IDX_LINE, 8'h00, {7'h0, exp_tx}, 0);
            end
        end
        apb(1, IDX_TXSEL, 8'h00, 8'h00, 0);
        apb(1, IDX_DIRECT, 8'h00, 8'h00, 0);
        // Receive destination, ready and live line state; line state ignores writes
        for (int d = 0; d < 8; d++) begin
            apb(1, IDX_RXSEL, {6'(rnd()), d[1:0]}, 8'h00, 0);
            apb(0, IDX_RXSEL, 8'h00, {6'h0, d[1:0]}, 0);
            rx  <= d[2];
            rdy <= d[0];
            repeat (5) @(posedge clk);
            check({31'h0, pb_rx}, {31'h0, d[1] & d[2]});
            check({31'h0, sci_rx}, {31'h0, d[0] & d[2]});
            check({31'h0, cap}, {31'h0, d[1] & d[2]});
            apb(1, IDX_LINE, 8'hFF, 8'h00, 0);
            apb(0, IDX_LINE, 8'h00, {d[0], 5'h0, d[2], 1'b0}, 0);
        end
        repeat (2) @(posedge clk);
        tally_and_finish();
    end
endmodule
